/* File: src/can_tx_pkg.sv */
package can_tx_pkg;
    // buffer geometry
    localparam int NUM_BUF       = 3;
    localparam int BUF_BYTES     = 14;
    localparam int BUF_DATA      = BUF_BYTES - 1;
    // device register map
    localparam logic [7:0] TXB_BASE        = 8'h30;
    localparam logic [7:0] TXB_STRIDE      = 8'h10;
    localparam logic [3:0] TXB_CTRL_OFS    = 4'h0;
    localparam logic [7:0] RTS_CFG_ADDR    = 8'h0D;
    localparam logic [7:0] CTRL_ADDR       = 8'h0F;
    localparam logic [7:0] IRQ_EN_ADDR     = 8'h2B;
    localparam logic [7:0] IRQ_FLAG_ADDR   = 8'h2C;
    // control byte fields
    localparam int CB_ABORTED  = 6;
    localparam int CB_LOST     = 5;
    localparam int CB_TX_ERROR_FLAG    = 4;
    localparam int CB_REQ      = 3;
    localparam int CB_PRIO_LSB = 0;
    // irq register fields
    localparam int IRQ_TX_LSB  = 2;
    localparam int IRQ_MERR    = 5;
    // controller control fields
    localparam int CTRL_ABORT_ALL = 4;
    // rts config fields
    localparam int RTS_LEVEL_LSB = 3;
    // priority codes
    localparam logic [1:0] PRIO_LOWEST  = 2'h0;
    localparam logic [1:0] PRIO_HIGHEST = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS     = 20;
    localparam int BIT_TIME_NS       = 1000;
    localparam int BIT_CYCLES        = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int INTERMISSION_BITS = 3;
    // host apb map
    localparam logic [7:0] APB_CMD_ADDR    = 8'h00;
    localparam logic [7:0] APB_STATUS_ADDR = 8'h04;
    localparam logic [7:0] APB_RTS_ADDR    = 8'h08;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WRITE     = 16;
    localparam int ST_RDATA_LSB  = 8;
    localparam int ST_INT        = 16;

    typedef enum logic [1:0] {
        SCH_IFS  = 2'b00,
        SCH_IDLE = 2'b01,
        SCH_TX   = 2'b10
    } sched_state_t;
endpackage

/* File: src/tx_link_if.sv */
`timescale 1ns/1ps
interface tx_link_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_we;
    logic       reg_re;
    logic [7:0] reg_rdata;
    logic       reg_ack;
    logic [2:0] rts_n;
    logic       int_n;

    modport dev (
        input  reg_addr, reg_wdata, reg_we, reg_re, rts_n,
        output reg_rdata, reg_ack, int_n
    );
    modport ctl (
        output reg_addr, reg_wdata, reg_we, reg_re, rts_n,
        input  reg_rdata, reg_ack, int_n
    );
endinterface

/* File: src/tx_buffer_manager.sv */
`timescale 1ns/1ps
module tx_buffer_manager
    import can_tx_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // controller side
    tx_link_if.dev          link,
    // protocol engine side
    input  wire logic       bus_recessive,
    input  wire logic       config_mode,
    input  wire logic       eng_ok,
    input  wire logic       eng_err,
    input  wire logic       eng_lost,
    input  wire logic [3:0] eng_addr,
    output logic            tx_start,
    output logic [1:0]      tx_sel,
    output logic [7:0]      eng_data
);
    import can_tx_pkg::*;

    logic [7:0]         mem [0:NUM_BUF*BUF_DATA-1];
    logic [NUM_BUF-1:0] req_reg;
    logic [1:0]         prio_reg [0:NUM_BUF-1];
    logic [NUM_BUF-1:0] aborted_reg;
    logic [NUM_BUF-1:0] lost_reg;
    logic [NUM_BUF-1:0] tx_error_flag_reg;
    logic [7:0]         irq_enable_reg;
    logic [7:0]         irq_flag_reg;
    logic [2:0]         rts_mode_reg;
    logic [2:0]         rts_prev_reg;
    logic               abort_all_reg;
    logic [7:0]         rdata_reg;
    logic               ack_reg;
    logic               int_n_reg;
    logic               start_reg;
    logic [1:0]         sel_reg;
    logic [7:0]         eng_data_reg;
    sched_state_t       state_reg;
    logic [5:0]         div_reg;
    logic [1:0]         ifs_reg;
    logic               bit_tick;
    logic               buf_hit;
    logic [1:0]         buf_idx;
    logic [3:0]         buf_ofs;
    logic               pick_valid;
    logic [1:0]         pick;
    logic [1:0]         best;
    logic               start_now;
    logic [7:0]         rd_mux;

    // buffer window decode
    always_comb begin
        buf_idx = 2'(link.reg_addr[7:4] - TXB_BASE[7:4]);
        buf_ofs = link.reg_addr[3:0];
        buf_hit = (link.reg_addr >= TXB_BASE)
               && (link.reg_addr < 8'(TXB_BASE + 8'(NUM_BUF) * TXB_STRIDE))
               && (buf_ofs < 4'(BUF_BYTES));
    end

    // bit time divider, restarted by a dominant bus and held during a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 6'h00;
        end else if (!bus_recessive || state_reg == SCH_TX || div_reg == 6'(BIT_CYCLES - 1)) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end
    assign bit_tick = (div_reg == 6'(BIT_CYCLES - 1));

    // priority pick over pending buffers
    always_comb begin
        pick_valid = 1'b0;
        pick       = 2'h0;
        best       = PRIO_LOWEST;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (req_reg[i] && (!pick_valid || prio_reg[i] >= best)) begin
                pick_valid = 1'b1;
                pick       = 2'(i);
                best       = prio_reg[i];
            end
        end
    end
    assign start_now = (state_reg == SCH_IDLE) && bus_recessive && pick_valid
                    && !abort_all_reg;

    // transmit scheduler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SCH_IFS;
            ifs_reg   <= 2'h0;
            start_reg <= 1'b0;
            sel_reg   <= 2'h0;
        end else begin
            start_reg <= 1'b0;
            unique case (state_reg)
                SCH_IFS: begin
                    if (!bus_recessive) begin
                        ifs_reg <= 2'h0;
                    end else if (bit_tick && ifs_reg == 2'(INTERMISSION_BITS - 1)) begin
                        ifs_reg   <= 2'h0;
                        state_reg <= SCH_IDLE;
                    end else if (bit_tick) begin
                        ifs_reg <= ifs_reg + 2'h1;
                    end
                end
                SCH_IDLE: begin
                    if (!bus_recessive) begin
                        state_reg <= SCH_IFS;
                    end else if (start_now) begin
                        start_reg <= 1'b1;
                        sel_reg   <= pick;
                        state_reg <= SCH_TX;
                    end
                end
                SCH_TX: begin
                    if (eng_ok || eng_err || eng_lost) begin
                        state_reg <= SCH_IFS;
                    end
                end
                default: state_reg <= SCH_IFS;
            endcase
        end
    end

    // per-buffer control state
    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++) begin : g_buf
            logic active;
            logic ctl_wr;
            logic pin_fall;
            logic set_req;
            assign active   = (state_reg == SCH_TX && sel_reg == 2'(g))
                           || (start_now && pick == 2'(g));
            assign ctl_wr   = link.reg_we && buf_hit && buf_idx == 2'(g)
                           && buf_ofs == TXB_CTRL_OFS;
            assign pin_fall = rts_mode_reg[g] && rts_prev_reg[g] && !link.rts_n[g];
            assign set_req  = (ctl_wr && link.reg_wdata[CB_REQ]) || pin_fall;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    req_reg[g]     <= 1'b0;
                    prio_reg[g]    <= PRIO_LOWEST;
                    aborted_reg[g] <= 1'b0;
                    lost_reg[g]    <= 1'b0;
                    tx_error_flag_reg[g]   <= 1'b0;
                end else begin
                    if (ctl_wr && !req_reg[g]) begin
                        prio_reg[g] <= link.reg_wdata[CB_PRIO_LSB +: 2];
                    end
                    if (set_req && !req_reg[g]) begin
                        req_reg[g]     <= 1'b1;
                        aborted_reg[g] <= 1'b0;
                        lost_reg[g]    <= 1'b0;
                        tx_error_flag_reg[g]   <= 1'b0;
                    end else if (state_reg == SCH_TX && sel_reg == 2'(g)) begin
                        if (eng_ok) begin
                            req_reg[g] <= 1'b0;
                        end else if (eng_err) begin
                            tx_error_flag_reg[g] <= 1'b1;
                        end else if (eng_lost) begin
                            lost_reg[g] <= 1'b1;
                        end
                    end else if (abort_all_reg && req_reg[g] && !active) begin
                        req_reg[g]     <= 1'b0;
                        aborted_reg[g] <= 1'b1;
                    end else if (ctl_wr && !link.reg_wdata[CB_REQ] && !active) begin
                        req_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // buffer byte storage, written only while the buffer has no pending request
    always_ff @(posedge pclk) begin
        if (link.reg_we && buf_hit && buf_ofs != TXB_CTRL_OFS && !req_reg[buf_idx]) begin
            mem[int'(buf_idx) * BUF_DATA + int'(buf_ofs) - 1] <= link.reg_wdata;
        end
    end

    // engine fetch port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_data_reg <= 8'h00;
        end else if (eng_addr != TXB_CTRL_OFS && eng_addr < 4'(BUF_BYTES)) begin
            eng_data_reg <= mem[int'(sel_reg) * BUF_DATA + int'(eng_addr) - 1];
        end else begin
            eng_data_reg <= 8'h00;
        end
    end

    // global registers and interrupt flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg <= 8'h00;
            irq_flag_reg   <= 8'h00;
            rts_mode_reg   <= 3'h0;
            rts_prev_reg   <= 3'h7;
            abort_all_reg  <= 1'b0;
            int_n_reg      <= 1'b1;
        end else begin
            rts_prev_reg <= link.rts_n;
            if (link.reg_we && link.reg_addr == IRQ_EN_ADDR) begin
                irq_enable_reg <= link.reg_wdata;
            end
            if (link.reg_we && link.reg_addr == RTS_CFG_ADDR && config_mode) begin
                rts_mode_reg <= link.reg_wdata[2:0];
            end
            if (link.reg_we && link.reg_addr == CTRL_ADDR) begin
                abort_all_reg <= link.reg_wdata[CTRL_ABORT_ALL];
            end
            // clears by writing zero; hardware sets win
            irq_flag_reg <= ((link.reg_we && link.reg_addr == IRQ_FLAG_ADDR)
                             ? (irq_flag_reg & link.reg_wdata) : irq_flag_reg)
                          | ((state_reg == SCH_TX && eng_ok)
                             ? 8'(8'h01 << (IRQ_TX_LSB + int'(sel_reg))) : 8'h00)
                          | ((state_reg == SCH_TX && eng_err)
                             ? 8'(8'h01 << IRQ_MERR) : 8'h00);
            int_n_reg <= ~|(irq_flag_reg & irq_enable_reg);
        end
    end

    // register read mux
    always_comb begin
        rd_mux = 8'h00;
        if (buf_hit && buf_ofs == TXB_CTRL_OFS) begin
            rd_mux[CB_ABORTED]        = aborted_reg[buf_idx];
            rd_mux[CB_LOST]           = lost_reg[buf_idx];
            rd_mux[CB_TX_ERROR_FLAG]          = tx_error_flag_reg[buf_idx];
            rd_mux[CB_REQ]            = req_reg[buf_idx];
            rd_mux[CB_PRIO_LSB +: 2]  = prio_reg[buf_idx];
        end else if (buf_hit) begin
            rd_mux = mem[int'(buf_idx) * BUF_DATA + int'(buf_ofs) - 1];
        end else if (link.reg_addr == IRQ_EN_ADDR) begin
            rd_mux = irq_enable_reg;
        end else if (link.reg_addr == IRQ_FLAG_ADDR) begin
            rd_mux = irq_flag_reg;
        end else if (link.reg_addr == CTRL_ADDR) begin
            rd_mux[CTRL_ABORT_ALL] = abort_all_reg;
        end else if (link.reg_addr == RTS_CFG_ADDR) begin
            rd_mux[2:0]                  = rts_mode_reg;
            rd_mux[RTS_LEVEL_LSB +: 3]   = rts_prev_reg;
        end
    end

    // register answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 8'h00;
            ack_reg   <= 1'b0;
        end else begin
            ack_reg <= link.reg_we || link.reg_re;
            if (link.reg_re) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign link.reg_rdata = rdata_reg;
    assign link.reg_ack   = ack_reg;
    assign link.int_n     = int_n_reg;
    assign tx_start       = start_reg;
    assign tx_sel         = sel_reg;
    assign eng_data       = eng_data_reg;
endmodule

/* File: src/tx_host_controller.sv */
`timescale 1ns/1ps
module tx_host_controller
    import can_tx_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // device side
    tx_link_if.ctl           link
);
    import can_tx_pkg::*;

    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  wdata_reg;
    logic        we_reg;
    logic        re_reg;
    logic        busy_reg;
    logic [7:0]  rdata_reg;
    logic [2:0]  rts_reg;
    logic        setup;
    logic        cmd_wr;

    assign setup  = psel && !penable;
    assign cmd_wr = psel && penable && pready_reg && pwrite && paddr == APB_CMD_ADDR;

    // apb answer in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && paddr != APB_CMD_ADDR && paddr != APB_STATUS_ADDR
                        && paddr != APB_RTS_ADDR;
            prdata_reg  <= 32'h0000_0000;
            if (setup && !pwrite && paddr == APB_STATUS_ADDR) begin
                prdata_reg[0]                  <= busy_reg;
                prdata_reg[ST_RDATA_LSB +: 8]  <= rdata_reg;
                prdata_reg[ST_INT]             <= ~link.int_n;
            end else if (setup && !pwrite && paddr == APB_CMD_ADDR) begin
                prdata_reg[7:0]                <= addr_reg;
                prdata_reg[CMD_WDATA_LSB +: 8] <= wdata_reg;
            end else if (setup && !pwrite && paddr == APB_RTS_ADDR) begin
                prdata_reg[2:0] <= rts_reg;
            end
        end
    end

    // relay one register access to the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg  <= 8'h00;
            wdata_reg <= 8'h00;
            we_reg    <= 1'b0;
            re_reg    <= 1'b0;
            busy_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            we_reg <= 1'b0;
            re_reg <= 1'b0;
            if (cmd_wr && !busy_reg) begin
                // software orders loads, enables and abort-all release
                addr_reg  <= pwdata[7:0];
                wdata_reg <= pwdata[CMD_WDATA_LSB +: 8];
                we_reg    <= pwdata[CMD_WRITE];
                re_reg    <= !pwdata[CMD_WRITE];
                busy_reg  <= 1'b1;
            end else if (busy_reg && link.reg_ack) begin
                busy_reg  <= 1'b0;
                rdata_reg <= link.reg_rdata;
            end
        end
    end

    // request-to-send pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_reg <= 3'h7;
        end else if (psel && penable && pready_reg && pwrite && paddr == APB_RTS_ADDR) begin
            rts_reg <= pwdata[2:0];
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign link.reg_addr  = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign link.reg_we    = we_reg;
    assign link.reg_re    = re_reg;
    assign link.rts_n     = rts_reg;
endmodule

/* File: tb/tx_link_monitor.sv */
`timescale 1ns/1ps
module tx_link_monitor (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // register port and pins
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic       reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack,
    input wire logic [2:0] rts_n,
    input wire logic       int_n
);
    import can_tx_pkg::*;

    logic [7:0] en_q;
    logic [3:0] seen_q;
    logic       rd_flag_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic is_buf(input logic [7:0] a);
        return (a[7:4] >= 4'h3) && (a[7:4] <= 4'h5) && (a[3:0] <= 4'hD);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return is_buf(a) || a == RTS_CFG_ADDR || a == CTRL_ADDR
            || a == IRQ_EN_ADDR || a == IRQ_FLAG_ADDR;
    endfunction

    // shadow of the interrupt enable byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h00;
        end else if (reg_we && reg_addr == IRQ_EN_ADDR) begin
            en_q <= reg_wdata;
        end
    end

    // marks the answer cycle of a flag read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_flag_q <= 1'b0;
        end else begin
            rd_flag_q <= reg_re && reg_addr == IRQ_FLAG_ADDR;
        end
    end

    // flags last seen set, dropped only by host clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 4'h0;
        end else if (reg_we && reg_addr == IRQ_FLAG_ADDR) begin
            seen_q <= seen_q & reg_wdata[5:2];
        end else if (rd_flag_q && reg_ack) begin
            seen_q <= reg_rdata[5:2];
        end
    end

    ack_follows_a: assert property ((reg_we || reg_re) |=> reg_ack)
        else $error("register request not answered next cycle");
    ack_cause_a: assert property (reg_ack |-> $past(reg_we || reg_re))
        else $error("register answer without a request");
    unmapped_zero_a: assert property (reg_re && !is_mapped(reg_addr) |=> reg_rdata == 8'h00)
        else $error("unmapped address read not zero");
    ctrl_spare_a: assert property (reg_re && is_buf(reg_addr) && reg_addr[3:0] == 4'h0
        |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0)
        else $error("unused control bits read nonzero");
    irq_pin_a: assert property (rd_flag_q && reg_ack
        |-> ((reg_rdata[5:2] & en_q[5:2]) != 4'h0) == !int_n)
        else $error("interrupt pin disagrees with enabled flags");
    irq_quiet_a: assert property (en_q[5:2] == 4'h0 && $past(en_q[5:2]) == 4'h0 |-> int_n)
        else $error("interrupt asserted with all enables clear");
    flag_sticky_a: assert property (rd_flag_q && reg_ack |-> (reg_rdata[5:2] & seen_q) == seen_q)
        else $error("interrupt flag dropped without host clear");
    pin_level_a: assert property (reg_re && reg_addr == RTS_CFG_ADDR && $stable(rts_n)
        && rts_n == $past(rts_n, 2) |=> reg_rdata[5:3] == rts_n && reg_rdata[7:6] == 2'h0)
        else $error("request pin levels misreported");

    // main scenarios reached
    cover property (reg_we ##1 reg_ack);
    cover property (rd_flag_q && reg_ack && !int_n);
    cover property (reg_re && reg_addr == RTS_CFG_ADDR);
endmodule

/* File: tb/test_can_transmit_buffer_manager.sv */
`timescale 1ns/1ps
module test_can_transmit_buffer_manager;
    import can_tx_pkg::*;

    // apb and engine stimulus
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_recessive;
    logic        config_mode;
    logic        eng_ok;
    logic        eng_err;
    logic        eng_lost;
    logic [3:0]  eng_addr;
    logic        tx_start;
    logic [1:0]  tx_sel;
    logic [7:0]  eng_data;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          mark = 0;
    int          start_count = 0;
    int          start_cyc = 0;
    int          seen = 0;

    // the two ends and the link between them
    tx_link_if link ();
    tx_host_controller i_tx_host_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    tx_buffer_manager i_tx_buffer_manager (.pclk(pclk), .presetn(presetn), .link(link),
        .bus_recessive(bus_recessive), .config_mode(config_mode), .eng_ok(eng_ok),
        .eng_err(eng_err), .eng_lost(eng_lost), .eng_addr(eng_addr), .tx_start(tx_start),
        .tx_sel(tx_sel), .eng_data(eng_data));
    tx_link_monitor i_tx_link_monitor (.pclk(pclk), .presetn(presetn),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_we(link.reg_we),
        .reg_re(link.reg_re), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
        .rts_n(link.rts_n), .int_n(link.int_n));

    // clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // cycle count and frame start log
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tx_start === 1'b1) begin
            start_count <= start_count + 1;
            start_cyc   <= cyc;
        end
    end

    function automatic logic [7:0] bufa(input int n, input logic [3:0] o);
        return TXB_BASE + TXB_STRIDE * 8'(n) + {4'h0, o};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: no pready", $time);
        end
    endtask

    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, APB_CMD_ADDR, {15'h0, w, d, a}, r, e);
        n = 0;
        do begin
            apb(1'b0, APB_STATUS_ADDR, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 50);
        if (r[0] !== 1'b0) begin
            bad_count++;
            $display("Error at %0t: device stays busy", $time);
        end
        q = r[ST_RDATA_LSB +: 8];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        dev(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] q;
        dev(1'b0, a, 8'h00, q);
        check(q & m, exp);
    endtask

    task automatic eng_pulse(input int k);
        @(posedge pclk);
        eng_ok   <= (k == 0);
        eng_err  <= (k == 1);
        eng_lost <= (k == 2);
        @(posedge pclk);
        eng_ok   <= 1'b0;
        eng_err  <= 1'b0;
        eng_lost <= 1'b0;
        mark = cyc;
    endtask

    task automatic wait_start(input logic [1:0] b, input logic [7:0] dat);
        int n;
        n = 0;
        while (start_count == seen && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        seen++;
        check({7'h0, (start_cyc - mark) >= 3 * BIT_CYCLES}, 8'h01);
        check({6'h0, tx_sel}, {6'h0, b});
        repeat (2) @(posedge pclk);
        check(eng_data, dat);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        check({7'h0, link.int_n}, 8'h01);
        for (int n = 0; n < NUM_BUF; n++) rd_check(bufa(n, 4'h0), 8'hFF, 8'h00);
        rd_check(IRQ_FLAG_ADDR, 8'hFF, 8'h00);
        rd_check(bufa(0, 4'hE), 8'hFF, 8'h00);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        check({7'h0, e}, 8'h01);
    endtask

    task automatic t_priority;
        int order[3] = '{1, 2, 0};
        wr(IRQ_EN_ADDR, 8'h3C);
        for (int n = 0; n < NUM_BUF; n++) wr(bufa(n, 4'h1), 8'hA0 + 8'(n));
        wr(bufa(0, 4'h0), 8'h09);
        wr(bufa(1, 4'h0), 8'h0B);
        wr(bufa(2, 4'h0), 8'h09);
        wr(bufa(1, 4'h1), 8'h55);
        check(8'(start_count), 8'h00);
        bus_recessive <= 1'b1;
        mark = cyc;
        for (int k = 0; k < 3; k++) begin
            wait_start(2'(order[k]), 8'hA0 + 8'(order[k]));
            eng_pulse(0);
            rd_check(bufa(order[k], 4'h0), 8'hFF, order[k] == 1 ? 8'h03 : 8'h01);
        end
        rd_check(IRQ_FLAG_ADDR, 8'hFF, 8'h1C);
        check({7'h0, link.int_n}, 8'h00);
        wr(IRQ_FLAG_ADDR, 8'h00);
        rd_check(IRQ_FLAG_ADDR, 8'hFF, 8'h00);
        check({7'h0, link.int_n}, 8'h01);
    endtask

    task automatic t_fail;
        wr(bufa(0, 4'h0), 8'h08);
        wait_start(2'h0, 8'hA0);
        wr(bufa(0, 4'h0), 8'h00);
        eng_pulse(1);
        rd_check(bufa(0, 4'h0), 8'hFF, 8'h18);
        rd_check(IRQ_FLAG_ADDR, 8'hFF, 8'h20);
        check({7'h0, link.int_n}, 8'h00);
        wait_start(2'h0, 8'hA0);
        eng_pulse(2);
        bus_recessive <= 1'b0;
        rd_check(bufa(0, 4'h0), 8'hFF, 8'h38);
        wr(bufa(0, 4'h0), 8'h00);
        rd_check(bufa(0, 4'h0), 8'hFF, 8'h30);
        wr(bufa(0, 4'h0), 8'h08);
        rd_check(bufa(0, 4'h0), 8'hFF, 8'h08);
        wr(IRQ_FLAG_ADDR, 8'h00);
    endtask

    task automatic t_abort;
        wr(bufa(2, 4'h0), 8'h0A);
        wr(CTRL_ADDR, 8'h10);
        rd_check(bufa(0, 4'h0), 8'hFF, 8'h40);
        rd_check(bufa(2, 4'h0), 8'hFF, 8'h42);
        wr(CTRL_ADDR, 8'h00);
        wr(bufa(2, 4'h0), 8'h0A);
        rd_check(bufa(2, 4'h0), 8'hFF, 8'h0A);
        bus_recessive <= 1'b1;
        mark = cyc;
        wait_start(2'h2, 8'hA2);
        eng_pulse(0);
        rd_check(bufa(2, 4'h0), 8'hFF, 8'h02);
        wr(IRQ_FLAG_ADDR, 8'h00);
    endtask

    task automatic t_rts;
        logic [31:0] r;
        logic        e;
        bus_recessive <= 1'b0;
        wr(RTS_CFG_ADDR, 8'h07);
        rd_check(RTS_CFG_ADDR, 8'h07, 8'h00);
        config_mode <= 1'b1;
        wr(RTS_CFG_ADDR, 8'h03);
        rd_check(RTS_CFG_ADDR, 8'h07, 8'h03);
        config_mode <= 1'b0;
        apb(1'b1, APB_RTS_ADDR, 32'h1, r, e);
        rd_check(bufa(1, 4'h0), 8'hFF, 8'h0B);
        rd_check(bufa(2, 4'h0), 8'hFF, 8'h02);
        apb(1'b1, APB_RTS_ADDR, 32'h7, r, e);
    endtask

    task tally_and_finish;
        $display("Compares %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        presetn       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 8'h00;
        pwdata        = 32'h0;
        bus_recessive = 1'b0;
        config_mode   = 1'b0;
        eng_ok        = 1'b0;
        eng_err       = 1'b0;
        eng_lost      = 1'b0;
        eng_addr      = 4'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_priority();
        t_fail();
        t_abort();
        t_rts();
        tally_and_finish();
    end

    // watchdog
    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
